// [hdl/pmi_phy_mgmt_irq.sv]
// Management link slave and interrupt logic of one integrated PHY.
`timescale 1ns/1ns
`include "pmi_defines.svh"
module pmi_phy_mgmt_irq
  import pmi_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int REASSERT_DELAY_CYC = `PMI_REASSERT_DELAY_MS * `PMI_CLK_KHZ,
  parameter int REASSERT_CYC = `PMI_REASSERT_MS * `PMI_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mdc_clk,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic internal_link_up_status,
  input wire logic line_energy_present,
  input wire pmi_stat_s stat,
  input wire logic renegotiate,
  input wire logic [3:0] wake_hit,
  output logic phy_irq
);

  // Link side, clocked by the management clock.
  pmi_frame_e frm_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic rd_sel_q;
  logic wr_sel_q;
  logic req_tgl_q;
  pmi_acc_s acc_q;
  logic [15:0] tx_q;
  logic mdio_o_q;
  logic mdio_oe_q;

  // Register side, clocked by ref_clk.
  logic req_s1_q, req_s2_q, req_s3_q;
  logic [15:0] rdata_q;
  logic [15:0] flags_q;
  logic [15:0] mask_q;
  logic alt_mode_q;
  logic [7:0] wake_q;
  logic [9:1] src_prev_q;
  logic reassert_armed_q;
  logic [31:0] delay_cnt_q;
  logic [31:0] pulse_cnt_q;
  logic delaying_q;
  logic pulsing_q;
  logic phy_irq_q;

  logic [9:1] src;
  logic [15:0] flags_d;
  logic acc_ev;
  logic acc_rd;
  logic acc_wr;
  logic combined_wake;

  function automatic logic hit(input logic ev, input logic [4:0] ra, input logic [4:0] want);
    hit = ev && (ra == want);
  endfunction : hit

  // Serial frame: preamble, start, opcode, addresses, turnaround, data.
  always_ff @(posedge mdc_clk or posedge rst) begin
    if (rst) begin
      frm_q <= PMI_S_PRE;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      rd_sel_q <= 1'b0;
      wr_sel_q <= 1'b0;
    end else begin
      sh_q <= {sh_q[14:0], mdio_i};
      case (frm_q)
        PMI_S_PRE: begin
          rd_sel_q <= 1'b0;
          wr_sel_q <= 1'b0;
          if (mdio_i) begin
            if (cnt_q != `PMI_PREAMBLE_ONES) begin
              cnt_q <= cnt_q + 5'd1;
            end
          end else begin
            if (cnt_q == `PMI_PREAMBLE_ONES) begin
              frm_q <= PMI_S_HDR;
            end
            cnt_q <= 5'h00;
          end
        end
        PMI_S_HDR: begin
          if (cnt_q == `PMI_HDR_LAST) begin
            cnt_q <= 5'h00;
            if (sh_q[11] && sh_q[8:4] == PHY_ADDR) begin
              frm_q <= PMI_S_TA;
              rd_sel_q <= ({sh_q[10:9]} == `PMI_OP_READ);
              wr_sel_q <= ({sh_q[10:9]} == `PMI_OP_WRITE);
            end else begin
              frm_q <= PMI_S_PRE;
            end
          end else begin
            cnt_q <= cnt_q + 5'd1;
          end
        end
        PMI_S_TA: begin
          if (cnt_q == 5'd1) begin
            cnt_q <= 5'h00;
            frm_q <= PMI_S_DATA;
          end else begin
            cnt_q <= cnt_q + 5'd1;
          end
        end
        PMI_S_DATA: begin
          if (cnt_q == `PMI_DATA_LAST) begin
            cnt_q <= 5'h00;
            frm_q <= PMI_S_PRE;
          end else begin
            cnt_q <= cnt_q + 5'd1;
          end
        end
        default: begin
          frm_q <= PMI_S_PRE;
          cnt_q <= 5'h00;
        end
      endcase
    end
  end

  // Access word and request toggle handed to ref_clk; the address field is also rewritten at the end of every header, even when the toggle does not move.
  always_ff @(posedge mdc_clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      req_tgl_q <= 1'b0;
    end else begin
      if (frm_q == PMI_S_HDR && cnt_q == `PMI_HDR_LAST && sh_q[11] && sh_q[8:4] == PHY_ADDR
          && {sh_q[10:9]} == `PMI_OP_READ) begin
        acc_q <= '{wr: 1'b0, regad: {sh_q[3:0], mdio_i}, wdata: 16'h0000};
        req_tgl_q <= ~req_tgl_q;
      end
      if (frm_q == PMI_S_HDR && cnt_q == `PMI_HDR_LAST) begin
        acc_q.regad <= {sh_q[3:0], mdio_i};
      end
      if (frm_q == PMI_S_DATA && cnt_q == `PMI_DATA_LAST && wr_sel_q) begin
        acc_q <= '{wr: 1'b1, regad: acc_q.regad, wdata: {sh_q[14:0], mdio_i}};
        req_tgl_q <= ~req_tgl_q;
      end
    end
  end

  // Read data leaves on rising edges; the word was fetched two management periods earlier.
  always_ff @(posedge mdc_clk or posedge rst) begin
    if (rst) begin
      tx_q <= 16'h0000;
      mdio_o_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      if (frm_q == PMI_S_TA && rd_sel_q && cnt_q == 5'd0) begin
        mdio_oe_q <= 1'b1;
        mdio_o_q <= 1'b0;
      end else if (frm_q == PMI_S_TA && rd_sel_q) begin
        mdio_o_q <= rdata_q[15];
        tx_q <= {rdata_q[14:0], 1'b0};
      end else if (frm_q == PMI_S_DATA && rd_sel_q && cnt_q != `PMI_DATA_LAST) begin
        mdio_o_q <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end else begin
        mdio_oe_q <= 1'b0;
        mdio_o_q <= 1'b0;
      end
    end
  end

  assign mdio_o = mdio_o_q;
  assign mdio_oe = mdio_oe_q;

  // Request toggle crossing into ref_clk.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  assign acc_ev = req_s2_q ^ req_s3_q;
  assign acc_rd = acc_ev && !acc_q.wr;
  assign acc_wr = acc_ev && acc_q.wr;
  assign combined_wake = |(wake_q[7:4] & wake_q[3:0]);

  // Source levels; link-down uses the inverted status so one rising edge sets every flag.
  always_comb begin
    src = '0;
    src[`PMI_BIT_LINKUP] = internal_link_up_status;
    src[`PMI_BIT_WAKE] = combined_wake;
    src[`PMI_BIT_ENERGY] = line_energy_present;
    src[`PMI_BIT_ANDONE] = stat.an_complete;
    src[`PMI_BIT_RFAULT] = stat.remote_fault;
    src[`PMI_BIT_LINKDN] = ~stat.link_status;
    src[`PMI_BIT_LPACK] = stat.lp_ack;
    src[`PMI_BIT_PDF] = stat.par_det_fault;
    src[`PMI_BIT_PAGE] = stat.page_received;
  end

  // Next flag value per cause; a set in the same cycle as a clear wins.
  always_comb begin
    logic rd_flags;
    logic rd_bstat;
    logic rd_anexp;
    logic link_loss;
    logic [9:1] clr;
    logic [9:1] rise;
    clr = '0;
    rd_flags = hit(acc_rd, acc_q.regad, `PMI_REG_FLAGS);
    rd_bstat = hit(acc_rd, acc_q.regad, `PMI_REG_BSTAT);
    rd_anexp = hit(acc_rd, acc_q.regad, `PMI_REG_ANEXP);
    link_loss = src[`PMI_BIT_LINKDN] && !src_prev_q[`PMI_BIT_LINKDN];
    rise = src & ~src_prev_q;
    if (alt_mode_q) begin
      clr = {9{hit(acc_wr, acc_q.regad, `PMI_REG_FLAGS)}} & acc_q.wdata[9:1] & ~src;
    end else begin
      clr = ~src & src_prev_q;
      clr[`PMI_BIT_LINKDN] = 1'b0;
      clr = clr | {9{rd_flags}};
      clr[`PMI_BIT_RFAULT] = clr[`PMI_BIT_RFAULT] | rd_bstat;
      clr[`PMI_BIT_LINKDN] = clr[`PMI_BIT_LINKDN] | rd_bstat;
      clr[`PMI_BIT_PDF] = clr[`PMI_BIT_PDF] | rd_anexp | renegotiate | link_loss;
      clr[`PMI_BIT_PAGE] = clr[`PMI_BIT_PAGE] | rd_anexp | renegotiate | link_loss;
    end
    flags_d = 16'h0000;
    flags_d[9:1] = rise | (flags_q[9:1] & ~clr);
  end

  // Flags; histories reset to idle levels, link-down high as the link is down after reset.
  // The energy history resets low so a live energy status flags at once.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_q <= 16'h0000;
      src_prev_q <= 9'h008;
    end else begin
      flags_q <= flags_d;
      src_prev_q <= src;
    end
  end

  // Mask, mode and wake control writes.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_q <= 16'h0000;
      alt_mode_q <= 1'b0;
      wake_q <= 8'h00;
    end else begin
      if (hit(acc_wr, acc_q.regad, `PMI_REG_MASK)) begin
        mask_q <= acc_q.wdata & `PMI_CAUSE_MASK;
      end
      if (hit(acc_wr, acc_q.regad, `PMI_REG_MODE)) begin
        alt_mode_q <= acc_q.wdata[`PMI_MODE_ALT_BIT];
      end
      if (hit(acc_wr, acc_q.regad, `PMI_REG_WAKE)) begin
        wake_q[7:4] <= acc_q.wdata[7:4];
        wake_q[3:0] <= wake_hit | (wake_q[3:0] & ~acc_q.wdata[3:0]);
      end else begin
        wake_q[3:0] <= wake_q[3:0] | wake_hit;
      end
    end
  end

  // Read data, latched in the cycle the request is taken.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (acc_rd) begin
      case (acc_q.regad)
        `PMI_REG_BSTAT: rdata_q <= {10'h000, stat.an_complete, stat.remote_fault, 1'b0,
                                    stat.link_status, 2'b00};
        `PMI_REG_LPABIL: rdata_q <= {1'b0, stat.lp_ack, 14'h0000};
        `PMI_REG_ANEXP: rdata_q <= {11'h000, stat.par_det_fault, 2'b00, stat.page_received, 1'b0};
        `PMI_REG_MODE: rdata_q <= {9'h000, alt_mode_q, 4'h0, line_energy_present, 1'b0};
        `PMI_REG_WAKE: rdata_q <= {8'h00, wake_q};
        `PMI_REG_FLAGS: rdata_q <= flags_q;
        `PMI_REG_MASK: rdata_q <= mask_q;
        default: rdata_q <= `PMI_UNMAPPED;
      endcase
    end
  end

  // Late energy re-assertion: armed when the energy flag is released with energy still present.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reassert_armed_q <= 1'b0;
      delaying_q <= 1'b0;
      pulsing_q <= 1'b0;
      delay_cnt_q <= 32'h0000_0000;
      pulse_cnt_q <= 32'h0000_0000;
    end else begin
      if (flags_q[`PMI_BIT_ENERGY] && !flags_d[`PMI_BIT_ENERGY] && line_energy_present
          && mask_q[`PMI_BIT_ENERGY]) begin
        reassert_armed_q <= 1'b1;
      end else if (reassert_armed_q && !line_energy_present && src_prev_q[`PMI_BIT_ENERGY]) begin
        reassert_armed_q <= 1'b0;
        delaying_q <= 1'b1;
        delay_cnt_q <= 32'h0000_0000;
      end
      if (delaying_q) begin
        if (delay_cnt_q == 32'(REASSERT_DELAY_CYC - 1)) begin
          delaying_q <= 1'b0;
          pulsing_q <= mask_q[`PMI_BIT_ENERGY];
          pulse_cnt_q <= 32'h0000_0000;
        end else begin
          delay_cnt_q <= delay_cnt_q + 32'h0000_0001;
        end
      end
      if (pulsing_q) begin
        if (pulse_cnt_q == 32'(REASSERT_CYC - 1) || !mask_q[`PMI_BIT_ENERGY]) begin
          pulsing_q <= 1'b0;
        end else begin
          pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // One interrupt line per PHY instance.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phy_irq_q <= 1'b0;
    end else begin
      phy_irq_q <= (|(flags_d & mask_q)) | pulsing_q;
    end
  end

  assign phy_irq = phy_irq_q;

endmodule : pmi_phy_mgmt_irq

// [hdl/pmi_defines.svh]
// Register indices, field positions and timing figures of the PHY management and interrupt block.
`ifndef PMI_DEFINES_SVH
`define PMI_DEFINES_SVH
`define PMI_REG_BSTAT 5'h01
`define PMI_REG_LPABIL 5'h05
`define PMI_REG_ANEXP 5'h06
`define PMI_REG_MODE 5'h11
`define PMI_REG_WAKE 5'h1A
`define PMI_REG_FLAGS 5'h1D
`define PMI_REG_MASK 5'h1E
`define PMI_UNMAPPED 16'hFFFF
`define PMI_CAUSE_MASK 16'h03FE
`define PMI_BIT_LINKUP 9
`define PMI_BIT_WAKE 8
`define PMI_BIT_ENERGY 7
`define PMI_BIT_ANDONE 6
`define PMI_BIT_RFAULT 5
`define PMI_BIT_LINKDN 4
`define PMI_BIT_LPACK 3
`define PMI_BIT_PDF 2
`define PMI_BIT_PAGE 1
`define PMI_MODE_ALT_BIT 6
`define PMI_MODE_ENERGY_BIT 1
`define PMI_CLK_KHZ 100000
`define PMI_REASSERT_DELAY_MS 1000
`define PMI_REASSERT_MS 256
`define PMI_PREAMBLE_ONES 5'd31
`define PMI_HDR_LAST 5'd12
`define PMI_DATA_LAST 5'd15
`define PMI_OP_READ 2'b10
`define PMI_OP_WRITE 2'b01
`endif

// [hdl/pmi_pkg.sv]
// Types shared by the PHY management and interrupt block.
package pmi_pkg;
  typedef enum logic [3:0] {
    PMI_S_PRE = 4'h1,
    PMI_S_HDR = 4'h2,
    PMI_S_TA = 4'h4,
    PMI_S_DATA = 4'h8
  } pmi_frame_e;

  typedef struct packed {
    logic wr;
    logic [4:0] regad;
    logic [15:0] wdata;
  } pmi_acc_s;

  typedef struct packed {
    logic an_complete;
    logic remote_fault;
    logic link_status;
    logic lp_ack;
    logic par_det_fault;
    logic page_received;
  } pmi_stat_s;
endpackage : pmi_pkg

// [sim/pmi_phy_mgmt_irq_asserts.sv]
// Checker for the management link and interrupt output of one PHY.
`timescale 1ns/1ns
module pmi_phy_mgmt_irq_chk
  import pmi_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int REASSERT_DELAY_CYC = 20,
  parameter int REASSERT_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mdc_clk,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic internal_link_up_status,
  input wire logic line_energy_present,
  input wire pmi_stat_s stat,
  input wire logic renegotiate,
  input wire logic [3:0] wake_hit,
  input wire logic phy_irq
);
  localparam int QUIET_LIM = REASSERT_DELAY_CYC + REASSERT_CYC + 40;
  logic [5:0] ones_q;
  logic [4:0] fcnt_q;
  logic [6:0] hdr_q;
  logic [13:0] in_q;
  int quiet_q;
  wire [13:0] in_now = {mdc_clk, internal_link_up_status, line_energy_present, stat, renegotiate, wake_hit};

  // Counts ref_clk cycles with no input change and no management clock activity.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_q <= '0;
      quiet_q <= 0;
    end else begin
      in_q <= in_now;
      quiet_q <= (in_now != in_q) ? 0 : ((quiet_q > QUIET_LIM) ? quiet_q : quiet_q + 1);
    end
  end

  // Tracks preamble, start and the bit position within a frame.
  always_ff @(posedge mdc_clk or posedge rst) begin
    if (rst) begin
      ones_q <= '0;
      fcnt_q <= '0;
      hdr_q <= '0;
    end else if (fcnt_q != 5'd0) begin
      fcnt_q <= fcnt_q + 5'd1;
      ones_q <= '0;
      if (fcnt_q >= 5'd2 && fcnt_q <= 5'd8) begin
        hdr_q <= {hdr_q[5:0], mdio_i};
      end
    end else if (mdio_i) begin
      ones_q <= (ones_q == 6'd32) ? ones_q : ones_q + 6'd1;
    end else begin
      fcnt_q <= (ones_q == 6'd32) ? 5'd1 : 5'd0;
      ones_q <= '0;
    end
  end

  sequence ta_then_data;
    !mdio_o ##1 mdio_oe [*8];
  endsequence
  sequence irq_low_two;
    !phy_irq ##1 !phy_irq;
  endsequence

  oe_start_a: assert property (@(posedge mdc_clk) disable iff (rst) $rose(mdio_oe) |-> fcnt_q == 5'd15)
    else $error("read drive began at the wrong bit");
  hdr_match_a: assert property (@(posedge mdc_clk) disable iff (rst)
    $rose(mdio_oe) |-> hdr_q == {2'b10, PHY_ADDR})
    else $error("read drive without a read to this address");
  ta_data_a: assert property (@(posedge mdc_clk) disable iff (rst) $rose(mdio_oe) |-> ta_then_data)
    else $error("turnaround or data drive wrong");
  oe_end_a: assert property (@(posedge mdc_clk) disable iff (rst)
    $fell(mdio_oe) |-> fcnt_q == 5'd0 || fcnt_q == 5'd31)
    else $error("read drive ended at the wrong bit");
  idle_release_a: assert property (@(posedge mdc_clk) disable iff (rst)
    fcnt_q == 5'd0 && ones_q > 6'd2 |-> !mdio_oe)
    else $error("data line driven outside a read");
  reset_irq_a: assert property (@(posedge ref_clk) disable iff (rst) $fell(rst) |-> irq_low_two)
    else $error("interrupt raised right after reset");
  quiet_irq_a: assert property (@(posedge ref_clk) disable iff (rst) quiet_q > QUIET_LIM |-> $stable(phy_irq))
    else $error("interrupt moved without a cause");
  ta_order_a: assert property (@(posedge mdc_clk) disable iff (rst) fcnt_q == 5'd14 |=> !$fell(mdio_oe))
    else $error("drive dropped during turnaround");
endmodule : pmi_phy_mgmt_irq_chk

bind pmi_phy_mgmt_irq pmi_phy_mgmt_irq_chk #(.PHY_ADDR(PHY_ADDR), .REASSERT_DELAY_CYC(REASSERT_DELAY_CYC),
  .REASSERT_CYC(REASSERT_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst), .mdc_clk(mdc_clk), .mdio_i(mdio_i),
  .mdio_o(mdio_o), .mdio_oe(mdio_oe), .internal_link_up_status(internal_link_up_status),
  .line_energy_present(line_energy_present), .stat(stat), .renegotiate(renegotiate), .wake_hit(wake_hit),
  .phy_irq(phy_irq));

// [sim/pmi_mgmt_master.sv]
// Station management master that runs frames on the serial management link.
`timescale 1ns/1ns
module pmi_mgmt_master #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  output logic mdc_clk,
  output logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  logic drv;
  logic dat;
  // The data line has a pull-up, so a released line reads high.
  assign mdio_i = mdio_oe ? mdio_o : (drv ? dat : 1'b1);

  initial begin
    mdc_clk = 1'b0;
    drv = 1'b0;
    dat = 1'b1;
  end

  // The clock runs inside frames and in idle; data changes after each falling edge.
  task automatic frame(input logic [63:0] bits, input logic [63:0] en, output logic [15:0] rd);
    #3;
    for (int i = 63; i >= 0; i--) begin
      drv = en[i];
      dat = bits[i];
      #80;
      if (i < 16) begin
        rd[i] = mdio_i;
      end
      mdc_clk = 1'b1;
      #80;
      mdc_clk = 1'b0;
    end
    drv = 1'b0;
  endtask : frame

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    frame({32'hFFFFFFFF, 4'b0110, PHY_ADDR, a, 18'h3FFFF}, {{46{1'b1}}, 18'h0}, d);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] unused;
    frame({32'hFFFFFFFF, 4'b0101, PHY_ADDR, a, 2'b10, d}, {64{1'b1}}, unused);
  endtask : wr

  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      #80;
      mdc_clk = 1'b1;
      #80;
      mdc_clk = 1'b0;
    end
  endtask : idle
endmodule : pmi_mgmt_master

// [sim/pmi_phy_mgmt_irq_tb_top.sv]
// Testbench for the management link and interrupt logic of one PHY.
`timescale 1ns/1ns
module pmi_phy_mgmt_irq_tb_top
  import pmi_pkg::*;
;
  logic ref_clk, rst, mdc_clk, mdio_i, mdio_o, mdio_oe, link_up, energy, reneg, phy_irq;
  pmi_stat_s stat;
  logic [3:0] wake_hit;
  logic [15:0] d;
  int bad_count;
  int compares;

  always #5 ref_clk = ~ref_clk;

  pmi_phy_mgmt_irq #(.PHY_ADDR(5'h01), .REASSERT_DELAY_CYC(20), .REASSERT_CYC(10)) uut (.ref_clk(ref_clk),
    .rst(rst), .mdc_clk(mdc_clk), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .internal_link_up_status(link_up), .line_energy_present(energy), .stat(stat), .renegotiate(reneg),
    .wake_hit(wake_hit), .phy_irq(phy_irq));
  pmi_mgmt_master #(.PHY_ADDR(5'h01)) mgr (.mdc_clk(mdc_clk), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe));

  task automatic finish_test();
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic irq_is(input logic v);
    tick(4);
    check("irq", {15'h0, phy_irq}, {15'h0, v});
  endtask : irq_is

  task automatic wait_irq(input logic v, input int n);
    int k;
    k = 0;
    while (phy_irq !== v && k < n) begin
      tick(1);
      k++;
    end
    check("irq wait", {15'h0, phy_irq}, {15'h0, v});
    if (phy_irq !== v) begin
      finish_test();
    end
  endtask : wait_irq

  // Cause 4 is raised by a low link status, all others by a high source.
  task automatic set_src(input int i, input logic v);
    tick(1);
    if (i == 9) begin
      link_up = v;
    end else if (i == 7) begin
      energy = v;
    end else begin
      stat[i-1] = (i == 4) ? !v : v;
    end
  endtask : set_src

  task automatic t_reset();
    mgr.rd(5'h1D, d);
    check("flags", d, 16'h0080);
    mgr.rd(5'h1D, d);
    check("flags", d, 16'h0000);
    mgr.rd(5'h11, d);
    check("mode", d & 16'h0042, 16'h0002);
    mgr.rd(5'h1E, d);
    check("mask", d, 16'h0000);
    mgr.rd(5'h02, d);
    check("unmapped", d, 16'hFFFF);
    mgr.wr(5'h1E, 16'hFFFF);
    mgr.rd(5'h1E, d);
    check("mask", d, 16'h03FE);
    set_src(7, 1'b0);
    irq_is(1'b0);
  endtask : t_reset

  task automatic t_primary();
    int src[8] = '{9, 7, 6, 5, 4, 3, 2, 1};
    int i;
    logic [4:0] a;
    foreach (src[k]) begin
      i = src[k];
      set_src(i, 1'b1);
      irq_is(1'b1);
      set_src(i, 1'b0);
      irq_is(i == 4);
      if (i == 4) begin
        mgr.rd(5'h01, d);
        irq_is(1'b0);
      end
      set_src(i, 1'b1);
      irq_is(1'b1);
      a = (i == 5) ? 5'h01 : ((i < 3) ? 5'h06 : 5'h1D);
      mgr.rd(a, d);
      if (a == 5'h1D) begin
        check("flags", d, 16'h0001 << i);
      end
      irq_is(1'b0);
      set_src(i, 1'b0);
      if (i == 7) begin
        wait_irq(1'b1, 40);
        wait_irq(1'b0, 20);
      end
    end
    set_src(2, 1'b1);
    tick(1);
    reneg = 1'b1;
    tick(1);
    reneg = 1'b0;
    irq_is(1'b0);
    set_src(2, 1'b0);
    set_src(1, 1'b1);
    set_src(4, 1'b1);
    mgr.rd(5'h1D, d);
    check("flags", d, 16'h0010);
    set_src(1, 1'b0);
    set_src(4, 1'b0);
  endtask : t_primary

  task automatic hit(input logic [3:0] h);
    tick(1);
    wake_hit = h;
    tick(1);
    wake_hit = 4'h0;
  endtask : hit

  task automatic t_wake();
    mgr.wr(5'h1A, 16'h0010);
    hit(4'h2);
    irq_is(1'b0);
    hit(4'h1);
    irq_is(1'b1);
    mgr.wr(5'h1A, 16'h0011);
    irq_is(1'b0);
  endtask : t_wake

  task automatic t_alt();
    int src[2] = '{6, 4};
    mgr.wr(5'h1E, 16'h037E);
    mgr.wr(5'h11, 16'h0040);
    mgr.rd(5'h11, d);
    check("mode", d & 16'h0040, 16'h0040);
    foreach (src[k]) begin
      set_src(src[k], 1'b1);
      irq_is(1'b1);
      mgr.wr(5'h1D, 16'h0001 << src[k]);
      irq_is(1'b1);
      set_src(src[k], 1'b0);
      irq_is(1'b1);
      mgr.wr(5'h1D, 16'h0001 << src[k]);
      irq_is(1'b0);
    end
  endtask : t_alt

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    link_up = 1'b0;
    energy = 1'b1;
    stat = 6'b001000;
    reneg = 1'b0;
    wake_hit = 4'h0;
    bad_count = 0;
    compares = 0;
    fork
      mgr.idle(2);
      tick(12);
    join
    tick(1);
    rst = 1'b0;
    t_reset();
    t_primary();
    t_wake();
    t_alt();
    tick(100);
    finish_test();
  end
endmodule : pmi_phy_mgmt_irq_tb_top
